// *** pkg/hub_cfg_pkg.sv ***
// Purpose: constants and types shared by the hub configuration bank
// Assumes: 8-bit register bus, byte address = 4 x register index
// Notes:   reset values and strap decode are plain defaults
package hub_cfg_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  // register indices; byte address is index * 4
  localparam logic [7:0]  CFG3_IDX      = 8'h08;
  localparam logic [7:0]  FIXMASK_IDX   = 8'h09;
  localparam logic [7:0]  STATUS_IDX    = 8'h10;
  localparam logic [7:0]  CFG3_ADDR     = {CFG3_IDX[5:0], 2'h0};
  localparam logic [7:0]  FIXMASK_ADDR  = {FIXMASK_IDX[5:0], 2'h0};
  localparam logic [7:0]  STATUS_ADDR   = {STATUS_IDX[5:0], 2'h0};
  // field positions in config byte three
  localparam int          STRING_BIT    = 0;
  localparam int          LIGHT_LSB     = 1;
  localparam int          LIGHT_MSB     = 2;
  localparam int          REMAP_BIT     = 3;
  localparam logic [7:0]  CFG3_USED     = 8'h0F;
  localparam logic [7:0]  FIXMASK_USED  = 8'hFE;
  localparam logic [7:0]  CFG3_RST      = 8'h00;
  localparam logic [7:0]  FIXMASK_RST   = 8'h00;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  // light mode codes; every code but SPEED means usb mode
  localparam logic [1:0]  LIGHT_SPEED   = 2'h1;
  // strap decode: 0 none, 1 port 1, 2 ports 1-2, 3 ports 1-3
  localparam logic [7:0]  STRAP_MASK_0  = 8'h00;
  localparam logic [7:0]  STRAP_MASK_1  = 8'h02;
  localparam logic [7:0]  STRAP_MASK_2  = 8'h06;
  localparam logic [7:0]  STRAP_MASK_3  = 8'h0E;
  // cycles after reset release before straps are trusted
  localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

  typedef enum logic [1:0] {
    ST_WAIT    = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } strap_state_t;

  typedef struct packed {
    logic       remap_mode;
    logic       speed_lights;
    logic       light_support;
    logic       string_support;
    logic       compound;
    logic [3:0] port_count;
    logic [7:0] fixed_ports;
    logic [7:0] reported_fixed;
  } hub_cfg_t;
endpackage

// *** rtl/hub_config_byte3_nonremovable.sv ***
// Purpose: config byte three and fixed-device port mask of the hub
// Assumes: straps and default select are pins; disable mask and
//          compound bit come from sibling registers on sys_clk
// Notes:   outputs feed the enumeration logic as one struct
// Summary of operation
// - bit 3 picks port numbering: 0 standard, 1 re-map
// - light field bits 2:1: 01 speed mode, other codes usb mode
// - light support reported to host only in usb light mode
// - bit 0 enables string descriptors, 0 disables them
// - mask bit n set marks port n fixed, clear removable
// - host learns which active ports hold fixed devices
// - mask bit 0 always held and read as zero
// - internal default takes fixed ports from strap pins
// - standard mode drops disabled ports, recounts, renumbers
// - strap-declared fixed port forces compound device report
`timescale 1ns/100ps
module hub_config_byte3_nonremovable
  import hub_cfg_pkg::*;
#(
  parameter int NUM_PORTS = 7
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // configuration source pins
  input  wire logic              use_internal_default,
  input  wire logic [1:0]        fixed_device_strap_pins,
  // sibling configuration, same clock
  input  wire logic              compound_cfg,
  input  wire logic [7:0]        self_powered_port_off_mask,
  // to enumeration logic
  output hub_cfg_t               hub_cfg,
  output logic                   cfg_ready
);

  logic [2:0]   pin_meta;
  logic [2:0]   pin_sync;
  strap_state_t state;
  strap_state_t next_state;
  logic [1:0]   settle_cnt;
  logic         strap_default;
  logic [7:0]   strap_mask;
  logic [7:0]   config_byte_three;
  logic [7:0]   fixed_device_port_mask;
  logic [7:0]   eff_fixed;
  logic [7:0]   compact_fixed;
  logic [3:0]   active_count;
  logic [3:0]   disabled_count;
  logic [1:0]   indicator_light_mode;
  logic         port_renumber_enable;
  hub_cfg_t     next_cfg;
  logic [7:0]   next_rdata;

  // pins come from outside; second flop alone is read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {use_internal_default, fixed_device_strap_pins};
      pin_sync <= pin_meta;
    end
  end

  // strap capture sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT:    if (settle_cnt == STRAP_SETTLE) next_state = ST_CAPTURE;
      ST_CAPTURE: next_state = ST_RUN;
      ST_RUN:     next_state = ST_RUN;
      default:    next_state = ST_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
    end else if (state == ST_WAIT && settle_cnt != STRAP_SETTLE) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // straps caught once after release; later pin motion is ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_default <= 1'b0;
      strap_mask    <= STRAP_MASK_0;
    end else if (state == ST_CAPTURE) begin
      strap_default <= pin_sync[2];
      case (pin_sync[1:0])
        2'h0:    strap_mask <= STRAP_MASK_0;
        2'h1:    strap_mask <= STRAP_MASK_1;
        2'h2:    strap_mask <= STRAP_MASK_2;
        default: strap_mask <= STRAP_MASK_3;
      endcase
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_byte_three <= CFG3_RST;
    end else if (reg_wr && reg_addr == CFG3_ADDR) begin
      config_byte_three <= reg_wdata & CFG3_USED;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fixed_device_port_mask <= FIXMASK_RST;
    end else if (reg_wr && reg_addr == FIXMASK_ADDR) begin
      fixed_device_port_mask <= reg_wdata & FIXMASK_USED;
    end
  end

  assign port_renumber_enable = config_byte_three[REMAP_BIT];
  assign indicator_light_mode = config_byte_three[LIGHT_MSB:LIGHT_LSB];

  // strap source overrides the register under the internal default
  assign eff_fixed = (strap_default ? strap_mask
                                    : fixed_device_port_mask) & FIXMASK_USED;

  // standard mode: skip disabled ports, renumber the rest densely
  always_comb begin
    active_count  = 4'h0;
    compact_fixed = 8'h00;
    for (int p = 1; p < 8; p++) begin
      if (p <= NUM_PORTS && !self_powered_port_off_mask[p]) begin
        active_count = active_count + 4'h1;
        compact_fixed[active_count[2:0]] = eff_fixed[p];
      end
    end
  end

  always_comb begin
    next_cfg                = '0;
    next_cfg.remap_mode     = port_renumber_enable;
    next_cfg.speed_lights   = (indicator_light_mode == LIGHT_SPEED);
    next_cfg.light_support  = (indicator_light_mode != LIGHT_SPEED);
    next_cfg.string_support = config_byte_three[STRING_BIT];
    next_cfg.compound       = compound_cfg |
                              (strap_default && eff_fixed != 8'h00);
    next_cfg.fixed_ports    = eff_fixed;
    if (port_renumber_enable) begin
      next_cfg.port_count     = 4'(NUM_PORTS);
      next_cfg.reported_fixed = eff_fixed;
    end else begin
      next_cfg.port_count     = active_count;
      next_cfg.reported_fixed = compact_fixed;
    end
  end

  // held at reset values until straps are known
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hub_cfg   <= '0;
      cfg_ready <= 1'b0;
    end else if (state == ST_RUN) begin
      hub_cfg   <= next_cfg;
      cfg_ready <= 1'b1;
    end
  end

  // read data valid in the cycle after the strobe only
  always_comb begin
    next_rdata = READ_ZERO;
    case (reg_addr)
      CFG3_ADDR:    next_rdata = config_byte_three;
      FIXMASK_ADDR: next_rdata = fixed_device_port_mask;
      STATUS_ADDR:  next_rdata = {hub_cfg.port_count, hub_cfg.compound,
                                  strap_default, hub_cfg.light_support,
                                  cfg_ready};
      default:      next_rdata = READ_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  assign disabled_count = 4'($countones(self_powered_port_off_mask[7:1]));

  a_remap_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN |=> hub_cfg.remap_mode == $past(config_byte_three[REMAP_BIT]))
    else $error("remap mode does not follow config bit 3");

  a_speed_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && indicator_light_mode == LIGHT_SPEED |=> hub_cfg.speed_lights
      && !hub_cfg.light_support)
    else $error("light code 01 not decoded as speed mode");

  a_light_report: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && indicator_light_mode != LIGHT_SPEED |=> hub_cfg.light_support
      && !hub_cfg.speed_lights)
    else $error("usb light mode not reported as supported");

  a_string_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN |=> hub_cfg.string_support == $past(config_byte_three[STRING_BIT]))
    else $error("string support does not follow bit 0");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == FIXMASK_ADDR |=> fixed_device_port_mask
      == ($past(reg_wdata) & FIXMASK_USED))
    else $error("fixed port mask write lost");

  a_mask_bit0_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !fixed_device_port_mask[0] && !hub_cfg.fixed_ports[0]
      && !hub_cfg.reported_fixed[0])
    else $error("fixed mask bit 0 not zero");

  a_remap_report: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && port_renumber_enable |=> hub_cfg.reported_fixed
      == $past(eff_fixed) && hub_cfg.port_count == 4'(NUM_PORTS))
    else $error("re-map mode report differs from fixed mask");

  a_strap_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && strap_default |=> hub_cfg.fixed_ports == $past(strap_mask))
    else $error("internal default ignores strap pins");

  a_std_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && !port_renumber_enable && NUM_PORTS == 7 |=>
      hub_cfg.port_count == 4'd7 - $past(disabled_count))
    else $error("standard mode port count wrong");

  a_strap_compound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && strap_default && strap_mask != 8'h00 |=> hub_cfg.compound)
    else $error("strapped fixed port without compound report");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == CFG3_ADDR |=> reg_rdata[7:4] == 4'h0
      && reg_rdata == $past(config_byte_three))
    else $error("config byte reserved bits not zero");

  a_ready_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(state == ST_CAPTURE) |=> ##1 cfg_ready)
    else $error("outputs not valid two cycles after capture");

  // checks on the view handed to enumeration and on the register port
  a_cfg3_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == CFG3_ADDR |=> config_byte_three
      == ($past(reg_wdata) & CFG3_USED))
    else $error("config byte write not masked to bits 3:0");

  a_mask_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == FIXMASK_ADDR |=> !reg_rdata[0])
    else $error("fixed mask bit 0 read back as one");

  a_light_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_ready |-> hub_cfg.speed_lights != hub_cfg.light_support)
    else $error("speed and usb light modes reported together");

  a_count_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_ready |-> hub_cfg.port_count <= 4'(NUM_PORTS))
    else $error("reported port count above port total");

  a_std_first_port: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && !port_renumber_enable && !self_powered_port_off_mask[1]
      |=> hub_cfg.reported_fixed[1] == $past(eff_fixed[1]))
    else $error("standard mode first port flag misplaced");

  a_reg_compound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN && !strap_default |=> hub_cfg.compound
      == $past(compound_cfg))
    else $error("compound report does not follow sibling bit");

  a_strap_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_RUN |=> $stable(strap_default) && $stable(strap_mask))
    else $error("strap values moved after capture");

  a_cfg_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cfg_ready |-> hub_cfg == '0)
    else $error("enumeration view not zero before ready");

  a_ready_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_ready |=> cfg_ready)
    else $error("ready dropped without reset");

  // idle read data is zero so a stale byte is never taken as an answer
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == READ_ZERO)
    else $error("read data not zero outside read cycle");

endmodule

// *** dv/usb_host_model.sv ***
// Purpose: host side view of what the hub reports at enumeration
// Assumes: host keeps the latest descriptor data once the hub is ready
// Notes:   no descriptor fetch for fixed devices is modelled
`timescale 1ns/100ps
module usb_host_model
  import hub_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // hub descriptor view
  input  wire hub_cfg_t   hub_cfg,
  input  wire logic       cfg_ready,
  // what enumeration learned
  output logic      [3:0] seen_ports,
  output logic      [7:0] seen_fixed
);
  // fixed devices answer for themselves, so only the flags are kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ports <= 4'h0;
      seen_fixed <= 8'h00;
    end else if (cfg_ready) begin
      seen_ports <= hub_cfg.port_count;
      seen_fixed <= hub_cfg.reported_fixed;
    end
  end
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench for config byte three and fixed port mask
// Assumes: full package, so every light mode has its pins
// Notes:   random register traffic plus a strap-configured restart
`timescale 1ns/100ps
module tb;
  import hub_cfg_pkg::*;
  logic       sys_clk, rst_n, reg_wr, reg_rd, use_internal_default, compound_cfg;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, self_powered_port_off_mask;
  logic [1:0] fixed_device_strap_pins;
  logic [3:0] seen_ports;
  logic [7:0] seen_fixed, c, m, d;
  hub_cfg_t   hub_cfg;
  hub_cfg_t   want;
  logic       cfg_ready;
  int         errors, check_count, seed;

  hub_config_byte3_nonremovable DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .use_internal_default(use_internal_default),
    .fixed_device_strap_pins(fixed_device_strap_pins), .compound_cfg(compound_cfg),
    .self_powered_port_off_mask(self_powered_port_off_mask), .hub_cfg(hub_cfg),
    .cfg_ready(cfg_ready));
  usb_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .hub_cfg(hub_cfg),
    .cfg_ready(cfg_ready), .seen_ports(seen_ports), .seen_fixed(seen_fixed));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check({24'h0, reg_rdata}, {24'h0, e});
    @(posedge sys_clk);
  endtask

  task automatic restart();
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 20 && cfg_ready !== 1'b1; n++) @(posedge sys_clk);
    check({31'h0, cfg_ready}, 32'h1);
  endtask

  // disabled ports drop out and the rest are renumbered densely in standard mode
  function automatic hub_cfg_t exp_cfg(input logic [7:0] c, input logic [7:0] m,
                                       input logic [7:0] d, input logic cmp);
    hub_cfg_t e;
    int       k;
    e = '0;
    k = 0;
    e.remap_mode = c[REMAP_BIT];
    e.speed_lights = (c[2:1] == 2'b01);
    e.light_support = (c[2:1] != 2'b01);
    e.string_support = c[STRING_BIT];
    e.compound = cmp;
    e.fixed_ports = m & 8'hFE;
    for (int p = 1; p <= 7; p++) if (c[REMAP_BIT] || !d[p]) begin
      k++;
      e.reported_fixed[k] = m[p];
    end
    e.port_count = k[3:0];
    return e;
  endfunction

  initial begin
    #(25ns * 4000);
    errors++;
    results();
  end

  initial begin
    seed = 74;
    {reg_wr, reg_rd, use_internal_default, compound_cfg} = 4'h0;
    {reg_addr, reg_wdata, self_powered_port_off_mask} = 24'h0;
    fixed_device_strap_pins = 2'h0;
    rst_n = 1'b0;
    @(posedge sys_clk);
    restart();
    rd(CFG3_ADDR, CFG3_RST);
    rd(FIXMASK_ADDR, FIXMASK_RST);
    rd(8'h30, READ_ZERO);
    for (int i = 0; i < 32; i++) begin
      c = 8'($random(seed));
      m = (i == 0) ? 8'hFF : 8'($random(seed));
      d = (i == 0) ? 8'hFE : (i == 1) ? 8'h00 : 8'($random(seed));
      // every light code is legal here since all indicator pins exist
      c[2:1] = i[1:0];
      want = exp_cfg(c, m, d, c[6]);
      compound_cfg <= c[6];
      self_powered_port_off_mask <= d;
      wr(CFG3_ADDR, c);
      wr(FIXMASK_ADDR, m);
      rd(CFG3_ADDR, c & 8'h0F);
      rd(FIXMASK_ADDR, m & 8'hFE);
      rd(STATUS_ADDR, {want.port_count, want.compound, 1'b0,
                       want.light_support, 1'b1});
      check({7'h0, hub_cfg}, {7'h0, want});
      check({28'h0, seen_ports}, {28'h0, want.port_count});
      check({24'h0, seen_fixed}, {24'h0, want.reported_fixed});
    end
    // strap-configured start: ports 1-2 fixed, no register mask written
    compound_cfg <= 1'b0;
    self_powered_port_off_mask <= 8'h00;
    use_internal_default <= 1'b1;
    fixed_device_strap_pins <= 2'b10;
    restart();
    wr(CFG3_ADDR, 8'h08);
    repeat (2) @(posedge sys_clk);
    check({7'h0, hub_cfg}, {7'h0, exp_cfg(8'h08, 8'h06, 8'h00, 1'b1)});
    check({24'h0, seen_fixed}, 32'h06);
    rd(STATUS_ADDR, 8'h7F);
    results();
  end
endmodule
